// ==== hdl/adrc_map.svh ====
// Constants for the dual receiver and control word block
`ifndef ADRC_MAP_SVH
`define ADRC_MAP_SVH

// ----------------------------------------------------------------
// Control word layout (index 0 sits on data bus bit 4)
// ----------------------------------------------------------------
`define ADRC_CFG_W 11
`define ADRC_CFG_BUS_LSB 4
`define ADRC_CFG_RESET 11'h002
`define ADRC_F_PAR_EN 0
`define ADRC_F_SELFTEST_N 1
`define ADRC_F_RX1_FLT 2
`define ADRC_F_RX1_M9 3
`define ADRC_F_RX1_M10 4
`define ADRC_F_RX2_FLT 5
`define ADRC_F_RX2_M9 6
`define ADRC_F_RX2_M10 7
`define ADRC_F_PAR_EVEN 8
`define ADRC_F_TX_RATE 9
`define ADRC_F_RX_RATE 10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADRC_REF_HZ 10000000
`define ADRC_MASTER_HZ 1000000
`define ADRC_PRESCALE (`ADRC_REF_HZ / `ADRC_MASTER_HZ)
`define ADRC_DIV_FAST 10
`define ADRC_DIV_SLOW 80
`define ADRC_OVERSAMPLE 10
`define ADRC_SMP_FAST (`ADRC_DIV_FAST / `ADRC_OVERSAMPLE)
`define ADRC_SMP_SLOW (`ADRC_DIV_SLOW / `ADRC_OVERSAMPLE)
`define ADRC_PULSE_MIN 5'h03
`define ADRC_PULSE_MAX 5'h08
`define ADRC_GAP_MAX 5'h0f
`define ADRC_WORD_BITS 6'h20

`endif

// ==== hdl/adrc_pkg.sv ====
// Types for the dual receiver and control word block
`default_nettype none
package adrc_pkg;
   typedef enum logic [3:0] {
      LS_NULL = 4'b0001,
      LS_ONE = 4'b0010,
      LS_ZERO = 4'b0100,
      LS_BAD = 4'b1000
   } adrc_line_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_PULSE = 3'b010,
      RX_GAP = 3'b100
   } adrc_rx_st_t;

   typedef struct packed {
      adrc_rx_st_t st;
      logic [4:0] run;
      logic bitv;
      logic [5:0] nbits;
      logic [31:0] sr;
      logic [31:0] word;
      logic vld;
   } adrc_rx_t;

   typedef struct packed {
      logic [1:0][31:0] mem;
      logic wp;
      logic rp;
      logic [1:0] cnt;
   } adrc_buf_t;

   typedef struct packed {
      logic [10:0] cfg;
      logic cws_prev;
      logic [3:0] pre;
      logic smp_tick;
      logic [2:0] smp_cnt;
      logic [6:0] txc_cnt;
      logic tx_clk;
      logic [1:0][31:0] hold;
      logic [1:0] rdy;
      logic [1:0][1:0] got;
      logic [1:0] stb_prev_n;
      logic [15:0] bd;
      logic tx_b32;
   } adrc_top_t;
endpackage : adrc_pkg
`default_nettype wire

// ==== hdl/adrc_buf.sv ====
// Two-entry word buffer with valid/ready on both sides
`default_nettype none
module adrc_buf (
   input wire logic clk,              // Clock
   input wire logic rst_n,            // Async reset, low
   input wire logic clr,              // Synchronous flush
   input wire logic in_valid,         // Word offered
   output logic in_ready,             // Room for a word
   input wire logic [31:0] in_data,   // Word in
   output logic out_valid,            // Word available
   input wire logic out_ready,        // Drain accepts
   output logic [31:0] out_data       // Oldest word
);
   adrc_pkg::adrc_buf_t q, d;

   assign in_ready = (q.cnt != 2'h2);
   assign out_valid = (q.cnt != 2'h0);
   assign out_data = q.mem[q.rp];

   always_comb begin
      logic push;
      logic pop;
      push = 1'b0;
      pop = 1'b0;
      d = q;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp = ~q.wp;
      end
      if (pop) begin
         d.rp = ~q.rp;
      end
      d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
      if (clr) begin
         d.wp = 1'b0;
         d.rp = 1'b0;
         d.cnt = 2'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : adrc_buf
`default_nettype wire

// ==== hdl/adrc_rx.sv ====
// One serial word receiver: line decode, bit timing, parity, label match
`include "adrc_map.svh"
`default_nettype none
module adrc_rx (
   input wire logic clk,              // Clock
   input wire logic rst_n,            // Async reset, low
   input wire logic clr,              // Master reset, aborts word
   input wire logic tick,             // Sample strobe, 10x data rate
   input wire logic line_one,         // Line in ONE state
   input wire logic line_zero,        // Line in ZERO state
   input wire logic flt_en,           // Label filter enable
   input wire logic m9,               // Match value for bit 9
   input wire logic m10,              // Match value for bit 10
   output logic [31:0] word,          // Accepted word
   output logic word_valid,           // Word waiting
   input wire logic word_ready        // Buffer accepts
);
   adrc_pkg::adrc_rx_t q, d;

   assign word = q.word;
   assign word_valid = q.vld;

   always_comb begin
      adrc_pkg::adrc_line_t ls;
      logic [31:0] full;
      logic abort;
      ls = adrc_pkg::LS_NULL;
      full = '0;
      abort = 1'b0;
      d = q;
      if (q.vld && word_ready) begin
         d.vld = 1'b0;
      end
      // Both comparators high is no legal level
      unique case ({line_one, line_zero})
         2'b00: ls = adrc_pkg::LS_NULL;
         2'b10: ls = adrc_pkg::LS_ONE;
         2'b01: ls = adrc_pkg::LS_ZERO;
         default: ls = adrc_pkg::LS_BAD;
      endcase
      // Line is looked at on each sample tick
      if (tick) begin
         unique case (q.st)
            adrc_pkg::RX_IDLE: begin
               if (ls == adrc_pkg::LS_ONE || ls == adrc_pkg::LS_ZERO) begin
                  d.st = adrc_pkg::RX_PULSE;
                  d.run = 5'h01;
                  d.bitv = (ls == adrc_pkg::LS_ONE);
                  d.nbits = 6'h00;
               end
            end
            adrc_pkg::RX_PULSE: begin
               if ((ls == adrc_pkg::LS_ONE && q.bitv) ||
                   (ls == adrc_pkg::LS_ZERO && !q.bitv)) begin
                  d.run = q.run + 5'h01;
                  abort = (q.run >= `ADRC_PULSE_MAX);
               end else if (ls == adrc_pkg::LS_NULL &&
                            q.run >= `ADRC_PULSE_MIN) begin
                  // First bit lands in bit 0 after 32 shifts
                  full = {q.bitv, q.sr[31:1]};
                  d.sr = full;
                  d.nbits = q.nbits + 6'h01;
                  d.st = adrc_pkg::RX_GAP;
                  d.run = 5'h01;
                  // Thirty-two good bits end the word
                  if (d.nbits == `ADRC_WORD_BITS) begin
                     d.st = adrc_pkg::RX_IDLE;
                     d.nbits = 6'h00;
                     // Bit 32 becomes the parity error flag
                     full[31] = ~(^full);
                     if (!flt_en || (full[8] == m9 && full[9] == m10)) begin
                        // A newer word replaces one not yet taken
                        d.word = full;
                        d.vld = 1'b1;
                     end
                  end
               end else begin
                  abort = 1'b1;
               end
            end
            adrc_pkg::RX_GAP: begin
               if (ls == adrc_pkg::LS_NULL) begin
                  d.run = q.run + 5'h01;
                  abort = (q.run >= `ADRC_GAP_MAX);
               end else if (ls == adrc_pkg::LS_BAD) begin
                  abort = 1'b1;
               end else begin
                  d.st = adrc_pkg::RX_PULSE;
                  d.run = 5'h01;
                  d.bitv = (ls == adrc_pkg::LS_ONE);
               end
            end
         endcase
      end
      // Out of range line or timing discards the word
      if (abort) begin
         d.st = adrc_pkg::RX_IDLE;
         d.nbits = 6'h00;
      end
      if (clr) begin
         d.st = adrc_pkg::RX_IDLE;
         d.nbits = 6'h00;
         d.vld = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: adrc_pkg::RX_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end
endmodule : adrc_rx
`default_nettype wire

// ==== hdl/adrc_top.sv ====
// Dual serial receiver with control word register and host read port
//
// What this block does
// - Eleven config flops capture bus on strobe
// - Bit 4 enables parity into transmit bit 32
// - Self-test low loops transmitter into receivers
// - Receiver one filter matches bits 9, 10
// - Receiver two filter with own match bits
// - Parity sense: 0 odd, 1 even
// - Transmit clock is master over 10 or 80
// - Receive clock is master over 10 or 80
// - Serial bit 1 comes first, ascending
// - Fixed byte 1 and byte 2 bit mapping
// - Illegal line states discard the word
// - Accept fast and slow word rates
// - Odd parity word stores bit 32 clear
// - Even parity word stores bit 32 set
// - Thirty-two valid bits raise end of word
// - End of word drives ready low if accepted
// - Ready stays low until both bytes read
// - New word overwrites unread stored word
// - Receiver two drives only if strobe one idle
// - Master reset clears receivers, keeps config
// - Sample line at ten times data rate
`include "adrc_map.svh"
`default_nettype none
module adrc_top (
   input wire logic REF_CLK,                 // Reference clock, 10 MHz
   input wire logic NRST,                    // Power-on reset, low
   input wire logic MASTER_RESET_N,          // Master reset, low
   input wire logic CONFIG_WRITE_STROBE,     // Control word write
   input wire logic [15:0] BD_IN,            // Data bus in
   output logic [15:0] BD_OUT,               // Data bus out
   output logic BD_OE,                       // Data bus drive enable
   input wire logic RX1_READ_STROBE_N,       // Read receiver one, low
   input wire logic RX2_READ_STROBE_N,       // Read receiver two, low
   input wire logic BYTE_SEL,                // 0 byte 1, 1 byte 2
   output logic RX1_WORD_READY_N,            // Receiver one ready, low
   output logic RX2_WORD_READY_N,            // Receiver two ready, low
   input wire logic RX1_LINE_ONE,            // Receiver one ONE level
   input wire logic RX1_LINE_ZERO,           // Receiver one ZERO level
   input wire logic RX2_LINE_ONE,            // Receiver two ONE level
   input wire logic RX2_LINE_ZERO,           // Receiver two ZERO level
   input wire logic TX_SERIAL_OUT,           // Transmitter ones output
   input wire logic TX_SERIAL_OUT_N,         // Transmitter zeroes output
   input wire logic [30:0] TX_WORD,          // Transmit bits 1 to 31
   input wire logic TX_WORD_BIT32,           // Transmit data bit 32
   output logic TX_BIT32,                    // Bit 32 to send
   output logic TX_PARITY_INSERT_ENABLE,     // Parity insert config
   output logic TX_CLK                       // Transmit data clock
);
   adrc_pkg::adrc_top_t q, d;

   logic [1:0] rx_one;
   logic [1:0] rx_zero;
   logic [1:0] rx_flt;
   logic [1:0] rx_m9;
   logic [1:0] rx_m10;
   logic [1:0][31:0] rx_word;
   logic [1:0] rx_vld;
   logic [1:0] rx_rdy;
   logic [1:0][31:0] bf_word;
   logic [1:0] bf_vld;
   logic [1:0] bf_rdy;
   logic [1:0] stb_n;
   logic mr_clr;
   logic self_test;

   assign mr_clr = ~MASTER_RESET_N;
   assign stb_n = {RX2_READ_STROBE_N, RX1_READ_STROBE_N};

   // ----------------------------------------------------------------
   // Line routing and receivers
   // ----------------------------------------------------------------
   // Loopback; receiver two sees the complement
   assign self_test = ~q.cfg[`ADRC_F_SELFTEST_N];
   assign rx_one[0] = self_test ? TX_SERIAL_OUT : RX1_LINE_ONE;
   assign rx_zero[0] = self_test ? TX_SERIAL_OUT_N : RX1_LINE_ZERO;
   assign rx_one[1] = self_test ? TX_SERIAL_OUT_N : RX2_LINE_ONE;
   assign rx_zero[1] = self_test ? TX_SERIAL_OUT : RX2_LINE_ZERO;

   assign rx_flt[0] = q.cfg[`ADRC_F_RX1_FLT];
   assign rx_m9[0] = q.cfg[`ADRC_F_RX1_M9];
   assign rx_m10[0] = q.cfg[`ADRC_F_RX1_M10];
   assign rx_flt[1] = q.cfg[`ADRC_F_RX2_FLT];
   assign rx_m9[1] = q.cfg[`ADRC_F_RX2_M9];
   assign rx_m10[1] = q.cfg[`ADRC_F_RX2_M10];

   // Store is held still while its strobe is low so a byte never changes
   // during its read; a new word can still load between the two byte reads
   assign bf_rdy = stb_n;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_rx
         adrc_rx u_rx (
            .clk(REF_CLK),
            .rst_n(NRST),
            .clr(mr_clr),
            .tick(q.smp_tick),
            .line_one(rx_one[gi]),
            .line_zero(rx_zero[gi]),
            .flt_en(rx_flt[gi]),
            .m9(rx_m9[gi]),
            .m10(rx_m10[gi]),
            .word(rx_word[gi]),
            .word_valid(rx_vld[gi]),
            .word_ready(rx_rdy[gi])
         );
         adrc_buf u_buf (
            .clk(REF_CLK),
            .rst_n(NRST),
            .clr(mr_clr),
            .in_valid(rx_vld[gi]),
            .in_ready(rx_rdy[gi]),
            .in_data(rx_word[gi]),
            .out_valid(bf_vld[gi]),
            .out_ready(bf_rdy[gi]),
            .out_data(bf_word[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Ready pins are the inverted flags
   assign RX1_WORD_READY_N = ~q.rdy[0];
   assign RX2_WORD_READY_N = ~q.rdy[1];
   // Drive only while a read strobe is low
   assign BD_OE = ~RX1_READ_STROBE_N | ~RX2_READ_STROBE_N;
   assign BD_OUT = q.bd;
   assign TX_CLK = q.tx_clk;
   assign TX_BIT32 = q.tx_b32;
   // Parity insert control to the transmitter
   assign TX_PARITY_INSERT_ENABLE = q.cfg[`ADRC_F_PAR_EN];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] w;
      logic [6:0] txdiv;
      logic [2:0] smpdiv;
      logic rd_sel;
      logic par_odd;
      w = '0;
      txdiv = '0;
      smpdiv = '0;
      rd_sel = 1'b0;
      par_odd = 1'b0;
      d = q;

      // Capture bus bits 14..4 on the strobe's rising edge
      d.cws_prev = CONFIG_WRITE_STROBE;
      if (CONFIG_WRITE_STROBE && !q.cws_prev) begin
         d.cfg = BD_IN[`ADRC_CFG_BUS_LSB +: `ADRC_CFG_W];
      end

      // Prescaler turns the reference into the 1 MHz master tick
      d.pre = q.pre + 4'h1;
      d.smp_tick = 1'b0;
      if (q.pre == 4'(`ADRC_PRESCALE - 1)) begin
         d.pre = 4'h0;
         smpdiv = q.cfg[`ADRC_F_RX_RATE] ? 3'(`ADRC_SMP_SLOW - 1) :
                                           3'(`ADRC_SMP_FAST - 1);
         d.smp_cnt = q.smp_cnt + 3'h1;
         if (q.smp_cnt >= smpdiv) begin
            d.smp_cnt = 3'h0;
            d.smp_tick = 1'b1;
         end
         // Transmit clock toggles each half period
         txdiv = q.cfg[`ADRC_F_TX_RATE] ? 7'(`ADRC_DIV_SLOW / 2 - 1) :
                                          7'(`ADRC_DIV_FAST / 2 - 1);
         d.txc_cnt = q.txc_cnt + 7'h01;
         if (q.txc_cnt >= txdiv) begin
            d.txc_cnt = 7'h00;
            d.tx_clk = ~q.tx_clk;
         end
      end

      // Bit 32 is parity or plain data
      par_odd = ~(^TX_WORD);
      d.tx_b32 = q.cfg[`ADRC_F_PAR_EN] ?
                 (par_odd ^ q.cfg[`ADRC_F_PAR_EVEN]) : TX_WORD_BIT32;

      // Receiver stores and ready flags
      d.stb_prev_n = stb_n;
      for (int i = 0; i < 2; i++) begin
         // A strobe's falling edge marks one byte read
         if (!stb_n[i] && q.stb_prev_n[i] &&
             (i == 0 || RX1_READ_STROBE_N)) begin
            d.got[i][BYTE_SEL] = 1'b1;
         end
         if (d.got[i] == 2'b11) begin
            d.rdy[i] = 1'b0;
            d.got[i] = 2'b00;
         end
         // New word loads and sets ready; load wins
         if (bf_vld[i] && bf_rdy[i]) begin
            d.hold[i] = bf_word[i];
            d.rdy[i] = 1'b1;
            d.got[i] = 2'b00;
         end
         // Master reset clears the store, config untouched
         if (mr_clr) begin
            d.rdy[i] = 1'b0;
            d.got[i] = 2'b00;
            d.hold[i] = '0;
         end
      end

      // Receiver two only when strobe one is high
      rd_sel = RX1_READ_STROBE_N;
      w = q.hold[rd_sel];
      // Byte packing of the stored word
      if (!BYTE_SEL) begin
         d.bd = {w[12], w[11], w[10], w[9], w[8],
                 w[30], w[29], w[31],
                 w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7]};
      end else begin
         d.bd = {w[28], w[27], w[26], w[25], w[24], w[23], w[22], w[21],
                 w[20], w[19], w[18], w[17], w[16], w[15], w[14], w[13]};
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         q <= '{cfg: `ADRC_CFG_RESET, stb_prev_n: 2'b11, default: '0};
      end else begin
         q <= d;
      end
   end
endmodule : adrc_top
`default_nettype wire

// ==== verification/adrc_line_src.sv ====
// Serial line source model driving one receiver's ONE and ZERO levels
`default_nettype none
module adrc_line_src (
   input wire logic clk,          // Clock
   input wire logic go,           // Start one word
   input wire logic [31:0] word,  // Word, bit 0 goes first
   input wire logic bad,          // Illegal state on the tenth bit
   input wire logic [7:0] spc,    // Clocks per receiver sample
   output logic one,              // ONE level
   output logic zero,             // ZERO level
   output logic busy              // Word in flight
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      int i;
      one = 1'b0;
      zero = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            busy <= 1'b1;
            // bit 1 first, at the selected rate
            for (i = 0; i < 32; i++) begin
               one <= word[i] | (bad && i == 9);
               zero <= !word[i] | (bad && i == 9);
               repeat (5 * spc) @(posedge clk);
               one <= 1'b0;
               zero <= 1'b0;
               repeat (5 * spc) @(posedge clk);
            end
            // Long gap so every word ends before the next starts
            repeat (40 * spc) @(posedge clk);
            busy <= 1'b0;
         end
      end
   end
endmodule : adrc_line_src
`default_nettype wire

// ==== verification/adrc_top_checker.sv ====
// Port checker for the dual receiver and control word block
`default_nettype none
module adrc_top_checker (
   input wire logic REF_CLK,                 // Clock
   input wire logic NRST,                    // Reset, low
   input wire logic MASTER_RESET_N,          // Master reset, low
   input wire logic CONFIG_WRITE_STROBE,     // Control write
   input wire logic [15:0] BD_IN,            // Bus in
   input wire logic [15:0] BD_OUT,           // Bus out
   input wire logic BD_OE,                   // Bus enable
   input wire logic RX1_READ_STROBE_N,       // Read one
   input wire logic RX2_READ_STROBE_N,       // Read two
   input wire logic BYTE_SEL,                // Byte select
   input wire logic RX1_WORD_READY_N,        // Ready one
   input wire logic RX2_WORD_READY_N,        // Ready two
   input wire logic [30:0] TX_WORD,          // Transmit word
   input wire logic TX_WORD_BIT32,           // Transmit bit 32
   input wire logic TX_BIT32,                // Bit 32 out
   input wire logic TX_PARITY_INSERT_ENABLE, // Parity enable
   input wire logic TX_CLK                   // Transmit clock
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   logic [10:0] cfg_q;
   logic cws_q;
   logic [9:0] cnt_q;
   logic [1:0] tg_q;
   logic cws_rise;
   assign cws_rise = CONFIG_WRITE_STROBE && !cws_q;
   // Shadow of the control word; toggles counted since the last write,
   // because the first half period after a rate change may be short
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         cfg_q <= 11'h002;
         cws_q <= 1'b0;
         cnt_q <= 10'h000;
         tg_q <= 2'h0;
      end else begin
         cws_q <= CONFIG_WRITE_STROBE;
         if (cws_rise) begin
            cfg_q <= BD_IN[14:4];
         end
         cnt_q <= $changed(TX_CLK) ? 10'h000 : cnt_q + 10'h001;
         if (cws_rise || !MASTER_RESET_N) begin
            tg_q <= 2'h0;
         end else if ($changed(TX_CLK) && tg_q != 2'h2) begin
            tg_q <= tg_q + 2'h1;
         end
      end
   end
   a_oe_follows_strobe: assert property (BD_OE ==
      (!RX1_READ_STROBE_N || !RX2_READ_STROBE_N))
      else $error("bus enable differs from read strobes");
   a_reset_clears_ready: assert property (!MASTER_RESET_N |=>
      RX1_WORD_READY_N && RX2_WORD_READY_N)
      else $error("ready flag survived master reset");
   a_cfg_capture: assert property ($rose(CONFIG_WRITE_STROBE) |=>
      TX_PARITY_INSERT_ENABLE == $past(BD_IN[4]))
      else $error("control write not captured");
   a_rx1_ready_clear: assert property ($rose(RX1_WORD_READY_N) |->
      !$past(MASTER_RESET_N) || !$past(RX1_READ_STROBE_N))
      else $error("ready one cleared without a read");
   a_rx2_ready_clear: assert property ($rose(RX2_WORD_READY_N) |->
      !$past(MASTER_RESET_N) ||
      (!$past(RX2_READ_STROBE_N) && $past(RX1_READ_STROBE_N)))
      else $error("ready two cleared without a read");
   a_tx_bit32_value: assert property (NRST |=> TX_BIT32 ==
      ($past(cfg_q[0]) ? (^$past(TX_WORD)) ^ !$past(cfg_q[8])
      : $past(TX_WORD_BIT32)))
      else $error("transmit bit 32 wrong");
   a_tx_clk_half: assert property ($changed(TX_CLK) && tg_q == 2'h2
      |-> cnt_q == (cfg_q[9] ? 10'h18f : 10'h031))
      else $error("transmit clock half period wrong");
   a_read_data_hold: assert property (!RX1_READ_STROBE_N &&
      $stable(RX1_READ_STROBE_N) && $stable(BYTE_SEL) &&
      $past(MASTER_RESET_N) |=> $stable(BD_OUT))
      else $error("read data moved during a read");
   c_rx1_word: cover property ($fell(RX1_WORD_READY_N));
   c_rx2_word: cover property ($fell(RX2_WORD_READY_N));
   c_both_strobes: cover property (!RX1_READ_STROBE_N && !RX2_READ_STROBE_N);
endmodule : adrc_top_checker
bind adrc_top adrc_top_checker u_adrc_top_checker (
   .REF_CLK(REF_CLK),
   .NRST(NRST),
   .MASTER_RESET_N(MASTER_RESET_N),
   .CONFIG_WRITE_STROBE(CONFIG_WRITE_STROBE),
   .BD_IN(BD_IN),
   .BD_OUT(BD_OUT),
   .BD_OE(BD_OE),
   .RX1_READ_STROBE_N(RX1_READ_STROBE_N),
   .RX2_READ_STROBE_N(RX2_READ_STROBE_N),
   .BYTE_SEL(BYTE_SEL),
   .RX1_WORD_READY_N(RX1_WORD_READY_N),
   .RX2_WORD_READY_N(RX2_WORD_READY_N),
   .TX_WORD(TX_WORD),
   .TX_WORD_BIT32(TX_WORD_BIT32),
   .TX_BIT32(TX_BIT32),
   .TX_PARITY_INSERT_ENABLE(TX_PARITY_INSERT_ENABLE),
   .TX_CLK(TX_CLK)
);
`default_nettype wire

// ==== verification/adrc_top_test.sv ====
// Self-checking bench for the dual receiver and control word block
`default_nettype none
module adrc_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic mrst_n = 1'b1;
   logic cws = 1'b0;
   logic sel = 1'b0;
   logic bad = 1'b0;
   logic [15:0] bd_in = 16'h0000;
   logic [1:0] stb_n = 2'b11;
   logic [1:0] go = 2'b00;
   logic [7:0] spc = 8'h0a;
   logic [31:0] sw = 32'h00000000;
   logic [31:0] rnd = 32'hd6737c22;
   logic [30:0] tx_word = 31'h00000000;
   logic tx_b32 = 1'b0;
   logic [1:0] rd_age = 2'h0;
   logic [15:0] bd_out;
   logic [1:0] rdy_n;
   logic [1:0] one;
   logic [1:0] zero;
   logic [1:0] busy;
   logic par_en;
   logic [15:0] expq[$];
   int failures = 0;
   int check_count = 0;
   always #50 ref_clk = ~ref_clk;
   adrc_top u_adrc_top (
      .REF_CLK(ref_clk), .NRST(nrst), .MASTER_RESET_N(mrst_n),
      .CONFIG_WRITE_STROBE(cws), .BD_IN(bd_in), .BD_OUT(bd_out),
      .BD_OE(), .RX1_READ_STROBE_N(stb_n[0]),
      .RX2_READ_STROBE_N(stb_n[1]), .BYTE_SEL(sel),
      .RX1_WORD_READY_N(rdy_n[0]), .RX2_WORD_READY_N(rdy_n[1]),
      .RX1_LINE_ONE(one[0]), .RX1_LINE_ZERO(zero[0]),
      .RX2_LINE_ONE(one[1]), .RX2_LINE_ZERO(zero[1]),
      .TX_SERIAL_OUT(one[0]), .TX_SERIAL_OUT_N(zero[0]), .TX_WORD(tx_word),
      .TX_WORD_BIT32(tx_b32), .TX_BIT32(), .TX_PARITY_INSERT_ENABLE(par_en),
      .TX_CLK());
   adrc_line_src src_a (.clk(ref_clk), .go(go[0]), .word(sw), .bad(bad),
      .spc(spc), .one(one[0]), .zero(zero[0]), .busy(busy[0]));
   adrc_line_src src_b (.clk(ref_clk), .go(go[1]), .word(sw), .bad(bad),
      .spc(spc), .one(one[1]), .zero(zero[1]), .busy(busy[1]));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic print_verdict();
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Random transmit data keeps the parity logic busy throughout
   always @(posedge ref_clk) begin
      rnd <= lfsr(rnd);
      {tx_b32, tx_word} <= rnd;
   end
   // Read data is valid one cycle after the strobe falls
   always @(posedge ref_clk)
      rd_age <= (stb_n != 2'b11) ? rd_age + 2'h1 : 2'h0;
   always @(negedge ref_clk)
      if (rd_age == 2'h1) check(bd_out, expq.pop_front());
   task automatic wcfg(input logic [10:0] c);
      @(posedge ref_clk);
      bd_in <= {1'b0, c, 4'h0};
      cws <= 1'b1;
      @(posedge ref_clk);
      cws <= 1'b0;
      // master reset after every control write
      @(posedge ref_clk);
      mrst_n <= 1'b0;
      @(posedge ref_clk);
      mrst_n <= 1'b1;
   endtask : wcfg
   task automatic rd(input int r, input logic s, input logic [15:0] e,
         input logic both);
      @(posedge ref_clk);
      // one strobe per receiver, byte chosen by select
      stb_n <= both ? 2'b00 : ~(2'b01 << r);
      sel <= s;
      expq.push_back(e);
      repeat (2) @(posedge ref_clk);
      stb_n <= 2'b11;
      @(posedge ref_clk);
   endtask : rd
   task automatic xfer(input int r, input logic [31:0] w, input logic b,
         input logic acc, input logic take);
      int n;
      logic [31:0] s;
      @(posedge ref_clk);
      sw <= w;
      bad <= b;
      go[r] <= 1'b1;
      @(posedge ref_clk);
      go <= 2'b00;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (busy[r] && n < 40000);
      if (n >= 40000) begin
         failures++;
         print_verdict();
      end
      check(16'(rdy_n[r]), 16'(!acc));
      if (take) begin
         s = {~^w, w[30:0]};
         rd(r, 1'b1, s[28:13], 1'b0);
         check(16'(rdy_n[r]), 16'h0000);
         rd(r, 1'b0, {s[12:8], s[30], s[29], s[31], s[0], s[1], s[2], s[3],
            s[4], s[5], s[6], s[7]}, r == 0);
         check(16'(rdy_n[r]), 16'h0001);
      end
   endtask : xfer
   initial begin
      int k;
      logic [31:0] w;
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      wcfg(11'h003);
      for (k = 0; k < 4; k++) begin
         w = rnd;
         w[31] = (^w[30:0]) ^ !k[1];
         xfer(k % 2, w, 1'b0, 1'b1, 1'b1);
      end
      xfer(0, rnd, 1'b0, 1'b1, 1'b0);
      xfer(0, ~rnd, 1'b0, 1'b1, 1'b1);
      // Self test: receiver two hears line one inverted
      wcfg(11'h001);
      w = rnd;
      xfer(0, w, 1'b0, 1'b1, 1'b1);
      w = ~w;
      rd(1, 1'b1, w[28:13], 1'b0);
      // Receiver one matches 1,0 and receiver two 0,1
      wcfg(11'h1af);
      for (k = 0; k < 4; k++) begin
         w = rnd;
         w[9:8] = {k[0], !k[0] ^ k[1]};
         xfer(k % 2, w, 1'b0, !k[1], !k[1]);
      end
      xfer(1, rnd, 1'b1, 1'b0, 1'b0);
      fork
         xfer(0, rnd, 1'b0, 1'b0, 1'b0);
         begin
            repeat (1500) @(posedge ref_clk);
            mrst_n <= 1'b0;
            @(posedge ref_clk);
            mrst_n <= 1'b1;
         end
      join
      check(16'(par_en), 16'h0001);
      spc <= 8'h50;
      wcfg(11'h603);
      xfer(1, rnd, 1'b0, 1'b1, 1'b1);
      print_verdict();
   end
endmodule : adrc_top_test
`default_nettype wire
